// File: rtl/fpm_pkg.sv
// Constants and carrier types for the flash power mode controller.
// Assumes a 16-bit register port on the system clock, 10 MHz.
`default_nettype none
package fpm_pkg;
   // Register word addresses
   localparam logic [15:0] ADDR_POWER_REQUEST = 16'h0a82;
   localparam logic [15:0] ADDR_POWER_STATUS = 16'h0a83;
   localparam logic [15:0] ADDR_SLEEP_STANDBY_WAIT = 16'h0a84;
   localparam logic [15:0] ADDR_STANDBY_ACTIVE_WAIT = 16'h0a85;

   // Field positions
   localparam int MODE_LSB = 0;
   localparam int STANDBY_RUN_BIT = 2;
   localparam int ACTIVE_RUN_BIT = 3;
   localparam int FAULT_BIT = 8;
   localparam int COUNT_W = 9;

   // Mode codes, shared by request and status fields
   localparam logic [1:0] MODE_SLEEP = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_RESERVED = 2'h2;
   localparam logic [1:0] MODE_ACTIVE = 2'h3;

   // Values after reset
   localparam logic [1:0] RST_POWER_REQUEST = 2'h0;
   localparam logic [8:0] RST_WAIT_COUNT = 9'h1ff;
   localparam logic [15:0] RST_READ_DATA = 16'h0000;

   // Register port request
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } fpm_bus_req_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_SLEEP = 3'b000,
      ST_TO_STANDBY = 3'b001,
      ST_STANDBY = 3'b010,
      ST_TO_ACTIVE = 3'b011,
      ST_ACTIVE = 3'b100
   } fpm_state_t;
endpackage
`default_nettype wire

// File: rtl/fpm_wait_timer.sv
// Down-counting transition wait timer.
// Assumes start and abort come from logic on the same clock.
`default_nettype none
module fpm_wait_timer (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Control
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic [8:0] count_i,
   // Status
   output logic busy_o,
   output logic done_o
);
   logic [8:0] cnt;
   logic [8:0] next_cnt;
   logic next_busy;
   logic next_done;

   // Busy for count_i cycles; a count of zero still takes one cycle
   always_comb begin
      next_cnt = cnt;
      next_busy = busy_o;
      next_done = 1'b0;
      if (abort_i) begin
         next_busy = 1'b0;
         next_cnt = 9'h000;
      end else if (start_i) begin
         next_busy = 1'b1;
         next_cnt = count_i;
      end else if (busy_o) begin
         if (cnt <= 9'h001) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_cnt = 9'h000;
         end else begin
            next_cnt = cnt - 9'h001;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cnt <= 9'h000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         busy_o <= next_busy;
         done_o <= next_done;
      end
   end
endmodule
`default_nettype wire

// File: rtl/fpm_ctrl.sv
// Flash bank and pump power mode controller with its four registers.
// Assumes the CPU port, override pulses, debug and lock flags share mclk_i;
// the pump supply signal is asynchronous and is synchronised here.
`default_nettype none
module fpm_ctrl (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Register port
   input wire fpm_pkg::fpm_bus_req_t bus_i,
   input wire logic debug_access_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   // Protection
   input wire logic write_protect_override_on_i,
   input wire logic write_protect_override_off_i,
   input wire logic code_security_unit_locked_i,
   // Pump and bank
   input wire logic pump_supply_out_of_range_i,
   output logic [1:0] pump_mode_o
);
   fpm_pkg::fpm_state_t state, next_state;
   logic [1:0] flash_power_request, next_flash_power_request;
   logic [8:0] sleep_standby_count, next_sleep_standby_count;
   logic [8:0] standby_active_count, next_standby_active_count;
   logic supply_fault_flag, next_supply_fault_flag;
   logic override_on, next_override_on;
   logic [15:0] next_rdata;
   logic next_rvalid;
   logic [1:0] next_pump_mode;
   logic fault_meta, fault_sync;
   logic wr_ok, rd_ok;
   logic standby_start, active_start, standby_abort, active_abort;
   logic standby_counter_running, active_counter_running;
   logic standby_done, active_done;
   logic [1:0] current_power_mode;

   // Mode reported for a sequencer state
   function automatic logic [1:0] state_mode(input fpm_pkg::fpm_state_t s);
      case (s)
         fpm_pkg::ST_STANDBY: state_mode = fpm_pkg::MODE_STANDBY;
         fpm_pkg::ST_TO_ACTIVE: state_mode = fpm_pkg::MODE_STANDBY;
         fpm_pkg::ST_ACTIVE: state_mode = fpm_pkg::MODE_ACTIVE;
         default: state_mode = fpm_pkg::MODE_SLEEP;
      endcase
   endfunction

   // Pump supply level is asynchronous to mclk_i
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         fault_meta <= 1'b0;
         fault_sync <= 1'b0;
      end else begin
         fault_meta <= pump_supply_out_of_range_i;
         fault_sync <= fault_meta;
      end
   end

   // Access qualification
   assign rd_ok = bus_i.rd && !code_security_unit_locked_i;
   assign wr_ok = bus_i.wr && !code_security_unit_locked_i
      && (override_on || debug_access_i);
   assign current_power_mode = state_mode(state);

   // Register file next values
   always_comb begin
      next_override_on = override_on;
      next_flash_power_request = flash_power_request;
      next_sleep_standby_count = sleep_standby_count;
      next_standby_active_count = standby_active_count;
      next_supply_fault_flag = supply_fault_flag;
      next_rdata = fpm_pkg::RST_READ_DATA;
      next_rvalid = bus_i.rd;
      // Off wins if both arrive together, the safer outcome
      if (write_protect_override_on_i) begin
         next_override_on = 1'b1;
      end
      if (write_protect_override_off_i) begin
         next_override_on = 1'b0;
      end
      if (wr_ok) begin
         case (bus_i.addr)
            fpm_pkg::ADDR_POWER_REQUEST: begin
               // Reserved code leaves the request unchanged
               if (bus_i.wdata[1:0] != fpm_pkg::MODE_RESERVED) begin
                  next_flash_power_request = bus_i.wdata[1:0];
               end
            end
            fpm_pkg::ADDR_POWER_STATUS: begin
               if (bus_i.wdata[fpm_pkg::FAULT_BIT]) begin
                  next_supply_fault_flag = 1'b0;
               end
            end
            fpm_pkg::ADDR_SLEEP_STANDBY_WAIT: begin
               next_sleep_standby_count = bus_i.wdata[8:0];
            end
            fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT: begin
               next_standby_active_count = bus_i.wdata[8:0];
            end
            default: begin
               next_flash_power_request = flash_power_request;
            end
         endcase
      end
      // A fault in the clearing cycle is kept
      if (fault_sync) begin
         next_supply_fault_flag = 1'b1;
      end
      // Locked or unmapped reads return zero, reserved bits zero
      if (rd_ok) begin
         case (bus_i.addr)
            fpm_pkg::ADDR_POWER_REQUEST: begin
               next_rdata = {14'h0000, flash_power_request};
            end
            fpm_pkg::ADDR_POWER_STATUS: begin
               next_rdata = {7'h00, supply_fault_flag, 4'h0,
                  active_counter_running, standby_counter_running,
                  current_power_mode};
            end
            fpm_pkg::ADDR_SLEEP_STANDBY_WAIT: begin
               next_rdata = {7'h00, sleep_standby_count};
            end
            fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT: begin
               next_rdata = {7'h00, standby_active_count};
            end
            default: begin
               next_rdata = fpm_pkg::RST_READ_DATA;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         override_on <= 1'b0;
         flash_power_request <= fpm_pkg::RST_POWER_REQUEST;
         sleep_standby_count <= fpm_pkg::RST_WAIT_COUNT;
         standby_active_count <= fpm_pkg::RST_WAIT_COUNT;
         supply_fault_flag <= 1'b0;
         rdata_o <= fpm_pkg::RST_READ_DATA;
         rvalid_o <= 1'b0;
      end else begin
         override_on <= next_override_on;
         flash_power_request <= next_flash_power_request;
         sleep_standby_count <= next_sleep_standby_count;
         standby_active_count <= next_standby_active_count;
         supply_fault_flag <= next_supply_fault_flag;
         rdata_o <= next_rdata;
         rvalid_o <= next_rvalid;
      end
   end

   // Sequencer: power-down is immediate, power-up waits out each stage
   always_comb begin
      next_state = state;
      standby_start = 1'b0;
      active_start = 1'b0;
      standby_abort = 1'b0;
      active_abort = 1'b0;
      case (state)
         fpm_pkg::ST_SLEEP: begin
            if (flash_power_request != fpm_pkg::MODE_SLEEP) begin
               next_state = fpm_pkg::ST_TO_STANDBY;
               standby_start = 1'b1;
            end
         end
         fpm_pkg::ST_TO_STANDBY: begin
            if (flash_power_request == fpm_pkg::MODE_SLEEP) begin
               next_state = fpm_pkg::ST_SLEEP;
               standby_abort = 1'b1;
            end else if (standby_done) begin
               next_state = fpm_pkg::ST_STANDBY;
            end
         end
         fpm_pkg::ST_STANDBY: begin
            if (flash_power_request == fpm_pkg::MODE_SLEEP) begin
               next_state = fpm_pkg::ST_SLEEP;
            end else if (flash_power_request == fpm_pkg::MODE_ACTIVE) begin
               next_state = fpm_pkg::ST_TO_ACTIVE;
               active_start = 1'b1;
            end
         end
         fpm_pkg::ST_TO_ACTIVE: begin
            if (flash_power_request != fpm_pkg::MODE_ACTIVE) begin
               next_state = (flash_power_request == fpm_pkg::MODE_SLEEP) ?
                  fpm_pkg::ST_SLEEP : fpm_pkg::ST_STANDBY;
               active_abort = 1'b1;
            end else if (active_done) begin
               next_state = fpm_pkg::ST_ACTIVE;
            end
         end
         fpm_pkg::ST_ACTIVE: begin
            if (flash_power_request == fpm_pkg::MODE_SLEEP) begin
               next_state = fpm_pkg::ST_SLEEP;
            end else if (flash_power_request == fpm_pkg::MODE_STANDBY) begin
               next_state = fpm_pkg::ST_STANDBY;
            end
         end
         default: begin
            next_state = fpm_pkg::ST_SLEEP;
         end
      endcase
      // Pump is driven toward the target of a running stage
      case (next_state)
         fpm_pkg::ST_TO_STANDBY: next_pump_mode = fpm_pkg::MODE_STANDBY;
         fpm_pkg::ST_TO_ACTIVE: next_pump_mode = fpm_pkg::MODE_ACTIVE;
         default: next_pump_mode = state_mode(next_state);
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state <= fpm_pkg::ST_SLEEP;
         pump_mode_o <= fpm_pkg::MODE_SLEEP;
      end else begin
         state <= next_state;
         pump_mode_o <= next_pump_mode;
      end
   end

   fpm_wait_timer u_standby_timer (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .start_i(standby_start),
      .abort_i(standby_abort),
      .count_i(sleep_standby_count),
      .busy_o(standby_counter_running),
      .done_o(standby_done)
   );

   fpm_wait_timer u_active_timer (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .start_i(active_start),
      .abort_i(active_abort),
      .count_i(standby_active_count),
      .busy_o(active_counter_running),
      .done_o(active_done)
   );
endmodule
`default_nettype wire

// File: verif/fpm_pump_model.sv
// Behavioural flash bank and pump seen from the controller's pump port.
// Assumes the bench commands supply excursions through glitch_i.
`default_nettype none
module fpm_pump_model (
   // Clock
   input wire logic mclk_i,
   // From controller
   input wire logic [1:0] pump_mode_i,
   // From bench
   input wire logic glitch_i,
   // To controller and bench
   output logic supply_out_of_range_o,
   output logic read_ready_o
);
   initial supply_out_of_range_o = 1'b0;
   initial read_ready_o = 1'b0;
   // Supply excursion is a plain level, as the pump reports it
   always @(posedge mclk_i) begin
      supply_out_of_range_o <= glitch_i;
      read_ready_o <= (pump_mode_i == fpm_pkg::MODE_ACTIVE);
   end
endmodule
`default_nettype wire

// File: verif/fpm_ctrl_chk.sv
// Port-level assertions for the flash power mode controller.
// Assumes it is bound into every fpm_ctrl instance.
`default_nettype none
module fpm_ctrl_chk (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Watched ports
   input wire fpm_pkg::fpm_bus_req_t bus_i,
   input wire logic [15:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic code_security_unit_locked_i,
   input wire logic [1:0] pump_mode_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   logic rd_st;
   logic rd_wt;
   assign rd_st = bus_i.rd && bus_i.addr == fpm_pkg::ADDR_POWER_STATUS;
   assign rd_wt = bus_i.rd && (bus_i.addr == fpm_pkg::ADDR_SLEEP_STANDBY_WAIT ||
      bus_i.addr == fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT);
   read_answered_a: assert property (bus_i.rd |=> rvalid_o)
      else $error("read not answered");
   lock_read_a: assert property (bus_i.rd && code_security_unit_locked_i
      |=> rdata_o == 16'h0000) else $error("locked read leaked data");
   pump_code_a: assert property (pump_mode_o != fpm_pkg::MODE_RESERVED)
      else $error("pump driven with reserved mode");
   up_in_steps_a: assert property ($changed(pump_mode_o)
      && pump_mode_o == fpm_pkg::MODE_ACTIVE |-> $past(pump_mode_o) == fpm_pkg::MODE_STANDBY)
      else $error("active entered from sleep");
   status_rsvd_a: assert property (rd_st
      |=> rdata_o[15:9] == 7'h00 && rdata_o[7:4] == 4'h0
      && rdata_o[1:0] != fpm_pkg::MODE_RESERVED) else $error("status reserved bits set");
   req_rsvd_a: assert property (bus_i.rd && bus_i.addr == fpm_pkg::ADDR_POWER_REQUEST
      |=> rdata_o[15:2] == 14'h0000) else $error("request reserved bits set");
   wait_width_a: assert property (rd_wt |=> rdata_o[15:9] == 7'h00)
      else $error("wait count wider than nine bits");
   one_timer_a: assert property (rd_st |=> !(rdata_o[2] && rdata_o[3]))
      else $error("both wait counters running");
   standby_mode_a: assert property (rd_st
      |=> !rdata_o[2] || rdata_o[1:0] == fpm_pkg::MODE_SLEEP)
      else $error("mode changed before standby wait expired");
   active_mode_a: assert property (rd_st
      |=> !rdata_o[3] || rdata_o[1:0] == fpm_pkg::MODE_STANDBY)
      else $error("mode wrong during active wait");
   cover property (rd_st ##1 rdata_o[3]);
   cover property (pump_mode_o == fpm_pkg::MODE_ACTIVE);
   cover property (rd_st ##1 rdata_o[8]);
endmodule
bind fpm_ctrl fpm_ctrl_chk i_chk (.mclk_i, .rst_b_i, .bus_i, .rdata_o, .rvalid_o,
   .code_security_unit_locked_i, .pump_mode_o);
`default_nettype wire

// File: verif/flash_power_mode_control_test.sv
// Self-checking bench for the flash power mode controller.
// Assumes the pump model and the bound checker are compiled alongside.
`default_nettype none
module flash_power_mode_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i, rst_b_i, dbg, ovr_on, ovr_off, lock, glitch, bad, ready, rvalid;
   fpm_pkg::fpm_bus_req_t bus;
   logic [15:0] rdata, rd_val;
   logic [1:0] pump_mode;
   int fails, check_count, cycles;
   fpm_ctrl i_dut (.mclk_i, .rst_b_i, .bus_i(bus), .debug_access_i(dbg), .rdata_o(rdata),
      .rvalid_o(rvalid), .write_protect_override_on_i(ovr_on),
      .write_protect_override_off_i(ovr_off), .code_security_unit_locked_i(lock),
      .pump_supply_out_of_range_i(bad), .pump_mode_o(pump_mode));
   fpm_pump_model i_pump (.mclk_i, .pump_mode_i(pump_mode), .glitch_i(glitch),
      .supply_out_of_range_o(bad), .read_ready_o(ready));
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   // About a hundred and ten cycles are needed; the ceiling leaves wide margin
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge mclk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge mclk_i);
      bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge mclk_i);
      bus.rd <= 1'b0;
      @(negedge mclk_i);
      rd_val = rdata;
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
   endtask
   task automatic ovr(input logic on);
      @(posedge mclk_i);
      ovr_on <= on;
      ovr_off <= !on;
      @(posedge mclk_i);
      ovr_on <= 1'b0;
      ovr_off <= 1'b0;
   endtask
   task automatic t_reset();
      rd(fpm_pkg::ADDR_POWER_REQUEST);
      chk("request", 16'h0000, rd_val);
      rd(fpm_pkg::ADDR_POWER_STATUS);
      chk("status", 16'h0000, rd_val);
      rd(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT);
      chk("sleep wait", 16'h01ff, rd_val);
      rd(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT);
      chk("active wait", 16'h01ff, rd_val);
      rd(16'h0a81);
      chk("unmapped", 16'h0000, rd_val);
      $display("test reset done");
   endtask
   task automatic t_protect();
      wr(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT, 16'h0003);
      rd(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT);
      chk("unprotected write", 16'h01ff, rd_val);
      ovr(1'b1);
      wr(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT, 16'hfe03);
      rd(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT);
      chk("sleep wait", 16'h0003, rd_val);
      ovr(1'b0);
      wr(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT, 16'h0005);
      rd(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT);
      chk("write after off", 16'h01ff, rd_val);
      @(posedge mclk_i);
      dbg <= 1'b1;
      wr(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT, 16'h0004);
      dbg <= 1'b0;
      rd(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT);
      chk("debug write", 16'h0004, rd_val);
      $display("test protect done");
   endtask
   task automatic t_lock();
      @(posedge mclk_i);
      lock <= 1'b1;
      ovr(1'b1);
      wr(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT, 16'h0006);
      rd(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT);
      chk("locked read", 16'h0000, rd_val);
      @(posedge mclk_i);
      lock <= 1'b0;
      rd(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT);
      chk("locked write", 16'h0003, rd_val);
      $display("test lock done");
   endtask
   task automatic t_power();
      logic saw_s;
      logic saw_a;
      wr(fpm_pkg::ADDR_POWER_REQUEST, 16'h0003);
      rd(fpm_pkg::ADDR_POWER_STATUS);
      saw_s = rd_val[2];
      saw_a = rd_val[3];
      chk("mode in wait", 16'h0000, {14'h0000, rd_val[1:0]});
      chk("pump standby", 16'h0001, {14'h0000, pump_mode});
      for (int n = 0; n < 40 && rd_val[1:0] !== fpm_pkg::MODE_ACTIVE; n++) begin
         rd(fpm_pkg::ADDR_POWER_STATUS);
         saw_s |= rd_val[2];
         saw_a |= rd_val[3];
      end
      chk("standby counter", 16'h0001, {15'h0000, saw_s});
      chk("active counter", 16'h0001, {15'h0000, saw_a});
      chk("status active", 16'h0003, rd_val);
      chk("bank ready", 16'h0001, {15'h0000, ready});
      wr(fpm_pkg::ADDR_POWER_REQUEST, 16'h0002);
      rd(fpm_pkg::ADDR_POWER_REQUEST);
      chk("reserved request", 16'h0003, rd_val);
      wr(fpm_pkg::ADDR_POWER_REQUEST, 16'h0000);
      rd(fpm_pkg::ADDR_POWER_STATUS);
      rd(fpm_pkg::ADDR_POWER_STATUS);
      chk("status sleep", 16'h0000, rd_val);
      chk("pump sleep", 16'h0000, {14'h0000, pump_mode});
      // Short counts were only for test time; put the defaults back
      wr(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT, 16'h01ff);
      wr(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT, 16'h01ff);
      rd(fpm_pkg::ADDR_SLEEP_STANDBY_WAIT);
      chk("sleep wait restored", 16'h01ff, rd_val);
      rd(fpm_pkg::ADDR_STANDBY_ACTIVE_WAIT);
      chk("active wait restored", 16'h01ff, rd_val);
      $display("test power done");
   endtask
   task automatic t_fault();
      @(posedge mclk_i);
      glitch <= 1'b1;
      repeat (5) @(posedge mclk_i);
      glitch <= 1'b0;
      rd(fpm_pkg::ADDR_POWER_STATUS);
      chk("fault set", 16'h0100, rd_val);
      wr(fpm_pkg::ADDR_POWER_STATUS, 16'h0000);
      rd(fpm_pkg::ADDR_POWER_STATUS);
      chk("fault kept", 16'h0100, rd_val);
      wr(fpm_pkg::ADDR_POWER_STATUS, 16'h0100);
      rd(fpm_pkg::ADDR_POWER_STATUS);
      chk("fault cleared", 16'h0000, rd_val);
      $display("test fault done");
   endtask
   initial begin
      bus = '0;
      {dbg, ovr_on, ovr_off, lock, glitch, rst_b_i} = 6'h00;
      fails = 0;
      check_count = 0;
      cycles = 0;
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_protect();
      t_lock();
      t_power();
      t_fault();
      finish_test();
   end
endmodule
`default_nettype wire
